//--- src/cpu_read_wait_irq.sv
// read strobe, ready handshake, interrupt sampling and wait-test logic
`timescale 1ns/1ps
module cpu_read_wait_irq (
  input  wire logic                 i_clk_sys,      // system clock
  input  wire logic                 i_sys_rst,      // sync reset
  input  wire logic                 i_cyc_start,    // core asks for cycle
  input  wire logic                 i_cyc_read,     // 1 read, 0 write
  input  wire logic                 i_cyc_mem,      // 1 memory, 0 i/o
  input  wire cpu_pins_pkg::xfer_t  i_cyc_width,    // transfer width
  input  wire logic                 i_bus_floated,  // local bus is hi-z
  input  wire logic                 i_hold_ack,     // bus granted away
  input  wire logic                 i_ready,        // ready from target
  input  wire logic                 i_last_cycle,   // last instr cycle
  input  wire logic                 i_irq_enable,   // interrupt flag
  input  wire logic                 i_maskable_irq_request, // irq level
  input  wire logic                 i_wait_instr,   // wait instr executing
  input  wire logic                 i_test_n,       // test input
  output logic                      o_rd_n,         // read strobe output
  output logic                      o_rd_n_oe,      // strobe output enable
  output logic                      o_mem_io,       // 1 memory, 0 i/o
  output logic                      o_high_byte_enable_n, // upper byte en
  output logic                      o_lowest_address_bit, // address bit
  output logic                      o_cyc_busy,     // bus cycle running
  output logic                      o_cyc_done,     // pulse at T4
  output logic                      o_irq_ack_start, // pulse: start ack
  output logic                      o_wait_stall    // core held in idle
);
  import cpu_pins_pkg::*;

  bus_state_t state_q;
  bus_state_t state_d;
  logic       read_q;
  logic       read_d;
  logic       mem_q;
  logic       mem_d;
  logic       bhe_n_q;
  logic       bhe_n_d;
  logic       a0_q;
  logic       a0_d;
  logic       rd_n_q;
  logic       rd_n_d;
  logic       irq_ack_q;
  logic       irq_ack_d;
  logic       stall_q;
  logic       stall_d;
  logic       test_s;

  // ---------------------------------------------------------------------
  // synchroniser for the test input
  // ---------------------------------------------------------------------
  test_sync u_test_sync (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_async   (i_test_n),
    .o_sync    (test_s)
  );

  // ---------------------------------------------------------------------
  // bus cycle sequencer
  // ---------------------------------------------------------------------
  // ready is used raw: the system delivers it synchronised already
  always_comb begin
    state_d = state_q;
    read_d  = read_q;
    mem_d   = mem_q;
    bhe_n_d = bhe_n_q;
    a0_d    = a0_q;
    case (state_q)
      ST_IDLE: begin
        if (i_cyc_start && !i_hold_ack) begin
          state_d = ST_T1;
          read_d  = i_cyc_read;
          mem_d   = i_cyc_mem;
          // width encoding on byte enable and address bit
          case (i_cyc_width)
            XFER_WORD: begin
              bhe_n_d = 1'b0;
              a0_d    = 1'b0;
            end
            XFER_HIGH: begin
              bhe_n_d = 1'b0;
              a0_d    = 1'b1;
            end
            XFER_LOW: begin
              bhe_n_d = 1'b1;
              a0_d    = 1'b0;
            end
            default: begin
              bhe_n_d = 1'b1;
              a0_d    = 1'b1;
            end
          endcase
        end
      end
      ST_T1:   state_d = ST_T2;
      ST_T2:   state_d = ST_T3;
      // ready checked late in T3 and in every wait state
      ST_T3:   state_d = i_ready ? ST_T4 : ST_WAIT;
      ST_WAIT: state_d = i_ready ? ST_T4 : ST_WAIT;
      ST_T4:   state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      state_q <= ST_IDLE;
      read_q  <= 1'b0;
      mem_q   <= 1'b0;
      bhe_n_q <= 1'b1;
      a0_q    <= 1'b1;
    end else begin
      state_q <= state_d;
      read_q  <= read_d;
      mem_q   <= mem_d;
      bhe_n_q <= bhe_n_d;
      a0_q    <= a0_d;
    end
  end

  // ---------------------------------------------------------------------
  // read strobe: registered so it never glitches on the pin
  // ---------------------------------------------------------------------
  // low from T2 through T3 and waits; T2 entry waits for bus float so a
  // target never fights the address drivers in T2; T3 drives it low regardless
  always_comb begin
    rd_n_d = STROBE_IDLE;
    if (read_q && !i_hold_ack) begin
      if (state_d == ST_T2 && i_bus_floated) begin
        rd_n_d = 1'b0;
      end else if (state_q == ST_T2 && i_bus_floated) begin
        rd_n_d = 1'b0;
      end else if (state_d == ST_T3 || state_d == ST_WAIT) begin
        rd_n_d = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      rd_n_q <= STROBE_IDLE;
    end else begin
      rd_n_q <= rd_n_d;
    end
  end

  // floated while granted; output value rests at one (bus hold)
  assign o_rd_n    = rd_n_q | i_hold_ack;
  assign o_rd_n_oe = !i_hold_ack;

  assign o_mem_io             = mem_q;
  assign o_high_byte_enable_n = bhe_n_q;
  assign o_lowest_address_bit = a0_q;
  assign o_cyc_busy           = (state_q != ST_IDLE);
  assign o_cyc_done           = (state_q == ST_T4);

  // ---------------------------------------------------------------------
  // interrupt sampling and wait-instruction stall
  // ---------------------------------------------------------------------
  // level sampled only in the last cycle; masked by the enable flag
  always_comb begin
    irq_ack_d = i_last_cycle && i_irq_enable
              && i_maskable_irq_request;
    // stall while test is high; recheck each clock until it falls
    stall_d   = i_wait_instr && test_s;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      irq_ack_q <= 1'b0;
      stall_q   <= 1'b0;
    end else begin
      irq_ack_q <= irq_ack_d;
      stall_q   <= stall_d;
    end
  end

  assign o_irq_ack_start = irq_ack_q;
  assign o_wait_stall    = stall_q;

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  rd_strobe_window_a: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (!o_rd_n && !i_hold_ack) |-> (state_q == ST_T2 ||
      state_q == ST_T3 || state_q == ST_WAIT))
    else $error("read strobe low outside T2/T3/wait");

  rd_in_t3_a: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (state_q == ST_T3 && read_q && !i_hold_ack) |-> !o_rd_n)
    else $error("read strobe not low in T3");

  rd_write_high_a: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (state_q != ST_IDLE && !read_q) |-> o_rd_n)
    else $error("read strobe low in write cycle");

  rd_float_a: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (state_q == ST_T2 && $fell(o_rd_n)) |-> $past(i_bus_floated))
    else $error("read strobe fell before bus floated");

  rd_hold_a: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    i_hold_ack |-> (!o_rd_n_oe && o_rd_n))
    else $error("read strobe driven while granted");

  ready_wait_a: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    ((state_q == ST_T3 || state_q == ST_WAIT) && !i_ready)
      |=> state_q == ST_WAIT)
    else $error("no wait state on low ready");

  ready_done_a: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    ((state_q == ST_T3 || state_q == ST_WAIT) && i_ready)
      |=> o_cyc_done ##1 !o_cyc_busy)
    else $error("cycle not ended after ready");

  irq_sample_a: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    o_irq_ack_start |-> $past(i_last_cycle && i_maskable_irq_request))
    else $error("irq taken outside last cycle");

  irq_mask_a: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (i_last_cycle && i_maskable_irq_request) |=>
      (o_irq_ack_start == $past(i_irq_enable)))
    else $error("irq mask not honoured");

  test_sync_a: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (i_wait_instr && !i_test_n) [*3] |=> !o_wait_stall)
    else $error("stall held after test low");

  width_enc_a: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (state_q == ST_IDLE && i_cyc_start && !i_hold_ack &&
      i_cyc_width == XFER_HIGH) |=>
      (!o_high_byte_enable_n && o_lowest_address_bit))
    else $error("upper byte encoding wrong");

endmodule

//--- src/cpu_pins_pkg.sv
// constants and types for the processor read strobe and wait/interrupt pins
// ---------------------------------------------------------------------------
// Behaviour
// - read strobe low marks read; mem/io select
// - strobe low in T2, T3, wait_state only
// - strobe held high until local bus floated (checked in T2 only; T3 drives it low regardless)
// - strobe floats at logic one when granted
// - irq level sampled in last instruction cycle
// - accepted irq starts acknowledge, vector fetch
// - irq ignored while enable flag clear
// - wait instruction idles until test low
// - test input synchronised every clock
// - byte enable and address bit encode width
// ---------------------------------------------------------------------------
package cpu_pins_pkg;

  // bus cycle states, binary coded
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_T1   = 3'h1,
    ST_T2   = 3'h2,
    ST_T3   = 3'h3,
    ST_WAIT = 3'h4,
    ST_T4   = 3'h5
  } bus_state_t;

  // transfer width codes requested by the core
  typedef enum logic [1:0] {
    XFER_NONE  = 2'h0,
    XFER_LOW   = 2'h1,
    XFER_HIGH  = 2'h2,
    XFER_WORD  = 2'h3
  } xfer_t;

  // resting level of the read strobe and synchroniser reset value
  localparam logic STROBE_IDLE = 1'b1;
  localparam logic SYNC_RESET  = 1'b1;

endpackage

//--- src/test_sync.sv
// two-stage synchroniser for the wait-instruction test input
`timescale 1ns/1ps
module test_sync (
  input  wire logic i_clk_sys,  // system clock
  input  wire logic i_sys_rst,  // sync reset, active high
  input  wire logic i_async,    // raw input
  output logic      o_sync      // synchronised level
);
  import cpu_pins_pkg::*;

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  // ---------------------------------------------------------------------
  // sample on every clock; first stage only feeds the second
  // ---------------------------------------------------------------------
  always_comb begin
    meta_d = i_async;
    sync_d = meta_q;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      meta_q <= SYNC_RESET;
      sync_q <= SYNC_RESET;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign o_sync = sync_q;
endmodule

//--- tb/mem_target.sv
// partner model: memory or i/o target answering the processor read cycle
`timescale 1ns/1ps
module mem_target (
  input  wire logic       i_clk_sys,  // system clock
  input  wire logic       i_busy,     // bus cycle running
  input  wire logic [3:0] i_waits,    // wait states to demand
  input  wire logic [3:0] i_fdly,     // extra clocks to release the bus
  output logic            o_ready,    // ready to the processor
  output logic            o_floated   // local bus released
);
  logic [4:0] cnt_q;
  // clocks since the cycle began; cleared between cycles
  always_ff @(posedge i_clk_sys) begin
    cnt_q <= i_busy ? cnt_q + 5'h1 : 5'h0;
  end
  // ready comes straight off the clock edge, so no resync is needed
  assign o_ready   = i_busy && (cnt_q >= 5'(i_waits) + 5'h2);
  // released already in T1 when no delay is asked, so the registered strobe
  // can fall on entry to T2; each extra clock holds the bus one state longer
  assign o_floated = i_busy && (cnt_q >= 5'(i_fdly));
endmodule

//--- tb/cpu_read_wait_irq_test.sv
// self-checking bench for read strobe, ready, interrupt and wait-test pins
`timescale 1ns/1ps
module cpu_read_wait_irq_test;
  import cpu_pins_pkg::*;
  typedef struct {
    logic       m;
    xfer_t      w;
    logic [3:0] ws;
    logic       high_byte_enable_n;
    logic       a0;
  } row_t;
  logic       clk = 1'b0, rst = 1'b1, start = 1'b0, mem = 1'b0;
  logic       hold = 1'b0, last = 1'b0, ien = 1'b0, irq = 1'b0;
  logic       rd = 1'b1;
  logic       winstr = 1'b0, test_n = 1'b1, ready, floated;
  logic       rd_n, oe, mem_io, high_byte_enable_n, a0, busy, done, ack, stall;
  logic [3:0] waits = 4'h0, fdly = 4'h0;
  xfer_t      width = XFER_NONE;
  int         fails = 0, n_checks = 0, n, lows;
  row_t rows [4] = '{'{1'b1, XFER_WORD, 4'h0, 1'b0, 1'b0},
                     '{1'b0, XFER_HIGH, 4'h1, 1'b0, 1'b1},
                     '{1'b1, XFER_LOW,  4'h2, 1'b1, 1'b0},
                     '{1'b0, XFER_NONE, 4'h3, 1'b1, 1'b1}};

  always #12.5 clk = ~clk;

  cpu_read_wait_irq dut (.i_clk_sys(clk), .i_sys_rst(rst),
    .i_cyc_start(start), .i_cyc_read(rd), .i_cyc_mem(mem),
    .i_cyc_width(width), .i_bus_floated(floated), .i_hold_ack(hold),
    .i_ready(ready), .i_last_cycle(last), .i_irq_enable(ien),
    .i_maskable_irq_request(irq), .i_wait_instr(winstr),
    .i_test_n(test_n), .o_rd_n(rd_n), .o_rd_n_oe(oe), .o_mem_io(mem_io),
    .o_high_byte_enable_n(high_byte_enable_n), .o_lowest_address_bit(a0),
    .o_cyc_busy(busy), .o_cyc_done(done), .o_irq_ack_start(ack),
    .o_wait_stall(stall));

  mem_target target (.i_clk_sys(clk), .i_busy(busy), .i_waits(waits),
    .i_fdly(fdly), .o_ready(ready), .o_floated(floated));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // start held until taken, since done and idle may not share an edge
  task automatic run(input logic m, input xfer_t w);
    int k;
    mem = m;
    width = w;
    start = 1'b1;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (busy !== 1'b1 && k < 10);
    start = 1'b0;
    n = 1;
    lows = 0;
    while (done !== 1'b1 && n < 30) begin
      if (rd_n === 1'b0) lows++;
      @(negedge clk);
      n++;
    end
  endtask

  // hang guard: whole run is under a hundred clocks
  initial begin
    #(25 * 3000);
    fails++;
    results();
  end

  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    chk("reset_outs", {rd_n, oe, mem_io, high_byte_enable_n, a0, busy, done, ack},
        8'hd8);
    $display("test reset done");
    foreach (rows[i]) begin
      waits = rows[i].ws;
      run(rows[i].m, rows[i].w);
      chk("done_cycle", 8'(n), 8'(4 + rows[i].ws));
      chk("strobe_low", 8'(lows), 8'(2 + rows[i].ws));
      chk("mem_io", {7'h0, mem_io}, {7'h0, rows[i].m});
      chk("bhe_a0", {6'h0, high_byte_enable_n, a0}, {6'h0, rows[i].high_byte_enable_n, rows[i].a0});
      chk("oe_free", {7'h0, oe}, 8'h01);
    end
    $display("test table done");
    // slow bus release delays the strobe but not the cycle
    waits = 4'h1;
    fdly = 4'h1;
    run(1'b1, XFER_WORD);
    chk("late_float_low", 8'(lows), 8'h02);
    chk("late_float_len", 8'(n), 8'h05);
    fdly = 4'h0;
    $display("test float done");
    // write cycle: the read strobe must stay high throughout
    rd = 1'b0;
    waits = 4'h0;
    run(1'b0, XFER_LOW);
    chk("write_no_strobe", 8'(lows), 8'h00);
    chk("write_len", 8'(n), 8'h04);
    chk("write_mem_io", {7'h0, mem_io}, 8'h00);
    rd = 1'b1;
    $display("test write done");
    // granted bus: strobe floats high and a request is refused
    hold = 1'b1;
    start = 1'b1;
    repeat (3) @(negedge clk);
    chk("hold_strobe", {6'h0, rd_n, oe}, 8'h02);
    chk("hold_busy", {7'h0, busy}, 8'h00);
    start = 1'b0;
    hold = 1'b0;
    @(negedge clk);
    $display("test hold done");
    // irq taken only in last cycle with enable set
    for (int i = 0; i < 4; i++) begin
      last = i[0];
      ien = i[1];
      irq = 1'b1;
      @(negedge clk);
      last = 1'b0;
      ien = 1'b0;
      chk("irq_ack", {7'h0, ack}, {7'h0, i == 3});
      @(negedge clk);
      chk("irq_ack_pulse", {7'h0, ack}, 8'h00);
    end
    irq = 1'b0;
    $display("test irq done");
    // wait instruction idles until the synchronised test goes low
    winstr = 1'b1;
    repeat (4) @(negedge clk);
    chk("stall_high", {7'h0, stall}, 8'h01);
    test_n = 1'b0;
    repeat (2) @(negedge clk);
    chk("stall_sync", {7'h0, stall}, 8'h01);
    @(negedge clk);
    chk("stall_exit", {7'h0, stall}, 8'h00);
    winstr = 1'b0;
    $display("test wait done");
    results();
  end
endmodule
